// ---- rx_decode_pkg.sv ----
// Purpose: shared constants, types and decode helpers for the rx path
// Assumes: plain register port, 16-bit register data
// Notes:   code-groups are written first-received bit first (msb)
package rx_decode_pkg;
  // register offsets
  localparam logic [7:0]  FALSE_CARRIER_OFFSET = 8'h14;
  localparam logic [7:0]  CTRL_OFFSET          = 8'h15;
  localparam logic [7:0]  ED_ON_OFFSET         = 8'h16;
  localparam logic [7:0]  ED_OFF_OFFSET        = 8'h17;
  localparam logic [7:0]  ED_LISTEN_OFFSET     = 8'h18;
  localparam logic [7:0]  STATUS_OFFSET        = 8'h19;
  // control fields and reset values
  localparam int          CTRL_RECOVERY_BIT    = 0;
  localparam int          CTRL_SYNC_FAIL_BIT   = 1;
  localparam int          CTRL_SPEED100_BIT    = 2;
  localparam logic [15:0] CTRL_RESET           = 16'h0004;
  localparam logic [15:0] ED_ON_RESET          = 16'h0030;
  localparam logic [15:0] ED_OFF_RESET         = 16'h0018;
  localparam logic [15:0] ED_LISTEN_RESET      = 16'h0040;
  localparam logic [15:0] FALSE_CARRIER_RESET  = 16'h0000;
  // code-groups and nibbles
  localparam logic [4:0]  CG_IDLE              = 5'h1F;
  localparam logic [4:0]  CG_J                 = 5'h18;
  localparam logic [4:0]  CG_K                 = 5'h11;
  localparam logic [4:0]  CG_T                 = 5'h0D;
  localparam logic [4:0]  CG_R                 = 5'h07;
  localparam logic [3:0]  PREAMBLE_NIBBLE      = 4'h5;
  localparam logic [3:0]  BAD_START_NIBBLE     = 4'hE;
  localparam logic [7:0]  SFD_BYTE             = 8'hD5;
  // equalizer, descrambler and detector constants (counts in symbols)
  localparam logic [7:0]  EQ_GAIN_RESET        = 8'h40;
  localparam logic [7:0]  EQ_STEP_FAST         = 8'h04;
  localparam logic [7:0]  EQ_STEP_SLOW         = 8'h01;
  localparam logic [11:0] EQ_FAST_SYMBOLS      = 12'h800;
  localparam logic [9:0]  EQ_TARGET            = 10'h040;
  localparam logic [9:0]  SLICE_LEVEL          = 10'h020;
  localparam logic [5:0]  LOCK_LOAD_BITS       = 6'h0B;
  localparam logic [5:0]  LOCK_DONE_BITS       = 6'h29;
  localparam logic [3:0]  MIN_IDLE_RUN         = 4'hA;
  localparam logic [2:0]  CAND_LAST_BIT        = 3'h6;
  localparam logic [2:0]  GROUP_LAST_BIT       = 3'h4;
  localparam int          ED_SHIFT             = 4;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_CAND = 2'b01, RX_PKT = 2'b11, RX_BAD = 2'b10
  } rx_state_t;

  typedef enum logic [1:0] {
    LINK_FAIL = 2'b00, LINK_UP = 2'b01, LINK_RECOVER = 2'b11
  } link_state_t;

  // 5b code-group to {valid, nibble}; control and invalid codes give valid 0
  function automatic logic [4:0] cg_decode(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    unique case (cg)
      5'h1E: r = 5'h10; 5'h09: r = 5'h11; 5'h14: r = 5'h12; 5'h15: r = 5'h13;
      5'h0A: r = 5'h14; 5'h0B: r = 5'h15; 5'h0E: r = 5'h16; 5'h0F: r = 5'h17;
      5'h12: r = 5'h18; 5'h13: r = 5'h19; 5'h16: r = 5'h1A; 5'h17: r = 5'h1B;
      5'h1A: r = 5'h1C; 5'h1B: r = 5'h1D; 5'h1C: r = 5'h1E; 5'h1D: r = 5'h1F;
      default: r = 5'h00;
    endcase
    return r;
  endfunction : cg_decode

  function automatic logic [9:0] mag10(input logic signed [9:0] v);
    return v[9] ? 10'(-v) : 10'(v);
  endfunction : mag10
endpackage : rx_decode_pkg

// ---- rx_decode_path.sv ----
// Purpose: receive line decoding for a 10/100 phy: equalizer gain, mlt-3,
//          descrambler lock, code-group alignment, bad start, link monitor
// Assumes: symbol clock arrives as a pin and is sampled by sys_clk_in
// Notes:   mii nibbles are marked by a one-cycle strobe, not a clock
`timescale 1ns/1ps
module rx_decode_path
  import rx_decode_pkg::*;
#(
  parameter int SYNC_LOSS_BITS = 16384,
  parameter int RECOVER_TICKS  = 2000
)
(
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        link_clk_in,
  input  wire logic [7:0]  pair_a_in,
  input  wire logic [7:0]  pair_b_in,
  input  wire logic        mdix_in,
  input  wire logic        tx_bit_in,
  input  wire logic        ten_bit_in,
  input  wire logic        ten_carrier_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  output logic      [3:0]  rxd_out,
  output logic             rx_dv_out,
  output logic             rx_er_out,
  output logic             crs_out,
  output logic             rx_strobe_out,
  output logic      [1:0]  tx_mlt3_out,
  output logic             tx_enable_out,
  output logic             link_up_out,
  output logic             signal_detect_out
);
  localparam logic [19:0] SYNC_LOSS_N = 20'(SYNC_LOSS_BITS);
  localparam logic [15:0] RECOVER_N   = 16'(RECOVER_TICKS);

  logic [20:0]        s1_q, s2_q;
  logic               lclk3_q, tick;
  logic signed [7:0]  samp;
  logic signed [16:0] prod;
  logic signed [9:0]  eq_q;
  logic [7:0]         gain_q, step;
  logic [11:0]        conv_q;
  logic [1:0]         lvl_q, lvl_d;
  logic               nrzi_q, nrzi_d, nrz, key, plain;
  logic [10:0]        lfsr_q;
  logic [5:0]         fill_q;
  logic               locked_q;
  logic [3:0]         run_q;
  logic [19:0]        wd_q;
  logic [14:0]        sh_q, sh_d;
  logic [2:0]         ph_q, ph_d;
  rx_state_t          st_q, st_d;
  logic [4:0]         prev_q, prev_d, dec;
  logic               kf_q, kf_d;
  logic               emit_v, emit_er, bad_inc;
  logic [3:0]         emit_n;
  logic [15:0]        fcc_q, ctrl_q, on_q, off_q, listen_q, lcnt_q;
  logic [9:0]         en_q, mag;
  logic signed [11:0] ed_diff;
  logic               sd_q;
  link_state_t        link_q;
  logic [15:0]        rec_q;
  logic [1:0]         txph_q, txph_d;
  logic               txnrzi_q, txnrzi_d;
  logic [7:0]         tsh_q, tsh_d;
  logic [3:0]         tnib_q, tnib_d;
  logic [1:0]         tcnt_q;
  logic               tal_q, t_emit;
  logic               speed100, rx_on;

  assign speed100 = ctrl_q[CTRL_SPEED100_BIT];
  assign rx_on    = locked_q & speed100;

  // two-flop synchronisers for every line-side pin (register port and reset are not synchronised); third flop finds clock edges
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      s1_q    <= '0;
      s2_q    <= '0;
      lclk3_q <= 1'b0;
    end
    else
    begin
      s1_q    <= {link_clk_in, pair_a_in, pair_b_in, mdix_in,
                  tx_bit_in, ten_bit_in, ten_carrier_in};
      s2_q    <= s1_q;
      lclk3_q <= s2_q[20];
    end

  assign tick = s2_q[20] & ~lclk3_q;
  assign samp = s2_q[3] ? $signed(s2_q[11:4]) : $signed(s2_q[19:12]);
  assign prod = samp * $signed({1'b0, gain_q});
  assign step = (conv_q < EQ_FAST_SYMBOLS) ? EQ_STEP_FAST : EQ_STEP_SLOW;
  assign mag  = mag10(eq_q);

  // equalizer: gain stepped toward target amplitude on signal symbols
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      eq_q   <= '0;
      gain_q <= EQ_GAIN_RESET;
      conv_q <= '0;
    end
    else if (tick)
    begin
      eq_q <= prod[15:6];
      // restart the fast schedule whenever energy is lost
      if (!sd_q)
        conv_q <= '0;
      else if (conv_q < EQ_FAST_SYMBOLS)
        conv_q <= conv_q + 12'h001;
      if (mag > SLICE_LEVEL && mag > EQ_TARGET && gain_q >= step)
        gain_q <= gain_q - step;
      else if (mag > SLICE_LEVEL && mag < EQ_TARGET && gain_q <= 8'hFF - step)
        gain_q <= gain_q + step;
    end

  // slicer and line decode: a level change is a one
  always_comb
  begin
    if (eq_q > $signed(SLICE_LEVEL))
      lvl_d = 2'b01;
    else if (eq_q < -$signed(SLICE_LEVEL))
      lvl_d = 2'b11;
    else
      lvl_d = 2'b00;
  end
  assign nrzi_d = (lvl_d != lvl_q);
  assign nrz    = nrzi_d ^ nrzi_q;
  assign key    = lfsr_q[10] ^ lfsr_q[8];
  assign plain  = nrz ^ key;
  assign sh_d   = {sh_q[13:0], plain};

  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      lvl_q  <= 2'b00;
      nrzi_q <= 1'b0;
    end
    else if (tick)
    begin
      lvl_q  <= lvl_d;
      nrzi_q <= nrzi_d;
    end

  // descrambler: idles are all ones, so inverted line bits load the state
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      lfsr_q   <= '0;
      fill_q   <= '0;
      locked_q <= 1'b0;
      run_q    <= '0;
      wd_q     <= '0;
    end
    else if (tick)
    begin
      run_q <= plain ? ((run_q < MIN_IDLE_RUN) ? run_q + 4'h1 : run_q) : 4'h0;
      if (!sd_q)
      begin
        locked_q <= 1'b0;
        fill_q   <= '0;
      end
      else if (!locked_q)
      begin
        if (fill_q < LOCK_LOAD_BITS)
        begin
          lfsr_q <= {lfsr_q[9:0], ~nrz};
          fill_q <= fill_q + 6'h01;
        end
        else if (!plain)
        begin
          lfsr_q <= {lfsr_q[9:0], ~nrz};
          fill_q <= 6'h01;
        end
        else
        begin
          lfsr_q <= {lfsr_q[9:0], key};
          fill_q <= fill_q + 6'h01;
          locked_q <= (fill_q == LOCK_DONE_BITS - 6'h01);
          wd_q <= '0;
        end
      end
      else
      begin
        lfsr_q <= {lfsr_q[9:0], key};
        // a run of idle ones proves the key is still right
        if (run_q == MIN_IDLE_RUN)
          wd_q <= '0;
        else if (wd_q == SYNC_LOSS_N)
        begin
          locked_q <= 1'b0;
          fill_q   <= '0;
        end
        else
          wd_q <= wd_q + 20'h00001;
      end
    end

  // alignment and code-group decision, valid on a symbol tick
  always_comb
  begin
    st_d    = st_q;
    ph_d    = (ph_q == GROUP_LAST_BIT) ? 3'h0 : ph_q + 3'h1;
    prev_d  = prev_q;
    kf_d    = kf_q;
    emit_v  = 1'b0;
    emit_n  = 4'h0;
    emit_er = 1'b0;
    bad_inc = 1'b0;
    dec     = cg_decode(prev_q);
    unique case (st_q)
      RX_IDLE:
        if (run_q == MIN_IDLE_RUN && !plain)
        begin
          st_d = RX_CAND;
          ph_d = 3'h0;
        end
      RX_CAND:
        if (ph_q != CAND_LAST_BIT)
          ph_d = ph_q + 3'h1;
        else if (sh_d == {CG_IDLE, CG_J, CG_K})
        begin
          st_d   = RX_PKT;
          ph_d   = 3'h0;
          emit_v = 1'b1;
          emit_n = PREAMBLE_NIBBLE;
          prev_d = CG_K;
          kf_d   = 1'b1;
        end
        else
        begin
          st_d    = RX_BAD;
          ph_d    = 3'h0;
          emit_v  = 1'b1;
          emit_n  = BAD_START_NIBBLE;
          emit_er = 1'b1;
          bad_inc = 1'b1;
        end
      RX_PKT:
        if (ph_q == GROUP_LAST_BIT)
        begin
          if (sh_d[9:0] == {CG_T, CG_R} || sh_d[9:0] == {CG_IDLE, CG_IDLE})
            st_d = RX_IDLE;
          else
          begin
            emit_v  = 1'b1;
            emit_n  = kf_q ? PREAMBLE_NIBBLE : dec[3:0];
            emit_er = ~kf_q & ~dec[4];
            prev_d  = sh_d[4:0];
            kf_d    = 1'b0;
          end
        end
      RX_BAD:
        if (ph_q == GROUP_LAST_BIT)
        begin
          if (sh_d[9:0] == {CG_IDLE, CG_IDLE})
            st_d = RX_IDLE;
          else
          begin
            emit_v  = 1'b1;
            emit_n  = BAD_START_NIBBLE;
            emit_er = 1'b1;
            bad_inc = 1'b1;
          end
        end
    endcase
  end

  // receive state is held idle while the descrambler is out of lock
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      st_q   <= RX_IDLE;
      ph_q   <= '0;
      sh_q   <= '0;
      prev_q <= '0;
      kf_q   <= 1'b0;
    end
    else if (tick)
    begin
      sh_q   <= sh_d;
      st_q   <= rx_on ? st_d : RX_IDLE;
      ph_q   <= ph_d;
      prev_q <= prev_d;
      kf_q   <= kf_d;
    end

  // false carrier count, saturating so software never sees a wrap
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
      fcc_q <= FALSE_CARRIER_RESET;
    else if (tick && rx_on && bad_inc && fcc_q != 16'hFFFF)
      fcc_q <= fcc_q + 16'h0001;

  // 10m path: hunt for the frame delimiter, then gather nibbles lsb first
  assign tsh_d  = {s2_q[1], tsh_q[7:1]};
  assign tnib_d = {s2_q[1], tnib_q[3:1]};
  assign t_emit = tick & !speed100 & tal_q & s2_q[0] & (tcnt_q == 2'h3);

  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      tsh_q  <= '0;
      tnib_q <= '0;
      tcnt_q <= '0;
      tal_q  <= 1'b0;
    end
    else if (tick && !speed100)
    begin
      if (!s2_q[0])
      begin
        tal_q <= 1'b0;
        tsh_q <= '0;
      end
      else if (!tal_q)
      begin
        tsh_q  <= tsh_d;
        tal_q  <= (tsh_d == SFD_BYTE);
        tcnt_q <= '0;
      end
      else
      begin
        tnib_q <= tnib_d;
        tcnt_q <= tcnt_q + 2'h1;
      end
    end

  // mii outputs, one flop stage from either speed path
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      rxd_out       <= 4'h0;
      rx_dv_out     <= 1'b0;
      rx_er_out     <= 1'b0;
      crs_out       <= 1'b0;
      rx_strobe_out <= 1'b0;
    end
    else
    begin
      rx_strobe_out <= 1'b0;
      if (!speed100)
      begin
        rx_dv_out <= tal_q & s2_q[0];
        crs_out   <= s2_q[0];
        rx_er_out <= 1'b0;
        if (t_emit)
        begin
          rxd_out       <= tnib_d;
          rx_strobe_out <= 1'b1;
        end
      end
      else if (!locked_q)
      begin
        rx_dv_out <= 1'b0;
        crs_out   <= 1'b0;
        rx_er_out <= 1'b0;
      end
      else if (tick)
      begin
        rx_dv_out <= (st_d == RX_PKT);
        crs_out   <= (st_d != RX_IDLE);
        if (st_d == RX_IDLE)
          rx_er_out <= 1'b0;
        if (emit_v)
        begin
          rxd_out       <= emit_n;
          rx_er_out     <= emit_er;
          rx_strobe_out <= 1'b1;
        end
      end
    end

  // energy detector: iir average of magnitude, hysteresis and listen time
  assign ed_diff = $signed({2'b00, mag}) - $signed({2'b00, en_q});

  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      en_q   <= '0;
      sd_q   <= 1'b0;
      lcnt_q <= '0;
    end
    else if (tick)
    begin
      en_q <= 10'($signed({2'b00, en_q}) + (ed_diff >>> ED_SHIFT));
      // the opposite threshold must hold for the whole listen time
      if (sd_q ? ({6'h00, en_q} < off_q) : ({6'h00, en_q} > on_q))
      begin
        if (lcnt_q >= listen_q)
        begin
          sd_q   <= ~sd_q;
          lcnt_q <= '0;
        end
        else
          lcnt_q <= lcnt_q + 16'h0001;
      end
      else
        lcnt_q <= '0;
    end

  // link monitor with its two optional extensions
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      link_q <= LINK_FAIL;
      rec_q  <= '0;
    end
    else
    begin
      rec_q <= '0;
      unique case (link_q)
        LINK_FAIL:
          if (sd_q && locked_q)
            link_q <= LINK_UP;
        LINK_UP:
          if (!sd_q)
            link_q <= ctrl_q[CTRL_RECOVERY_BIT] ? LINK_RECOVER : LINK_FAIL;
          else if (ctrl_q[CTRL_SYNC_FAIL_BIT] && !locked_q)
            link_q <= LINK_FAIL;
        LINK_RECOVER:
          if (sd_q && locked_q)
            link_q <= LINK_UP;
          else if (rec_q == RECOVER_N)
            link_q <= LINK_FAIL;
          else
            rec_q <= rec_q + 16'h0001;
      endcase
    end

  // transmit line encoder: nrzi first, three-level code steps on each nrzi one
  assign txnrzi_d = txnrzi_q ^ s2_q[2];
  assign txph_d   = txnrzi_d ? txph_q + 2'h1 : txph_q;

  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      txnrzi_q    <= 1'b0;
      txph_q      <= 2'h0;
      tx_mlt3_out <= 2'b00;
    end
    else if (tick)
    begin
      txnrzi_q    <= txnrzi_d;
      txph_q      <= txph_d;
      tx_mlt3_out <= txph_d[0] ? {txph_d[1], 1'b1} : 2'b00;
    end

  // status flops
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      tx_enable_out     <= 1'b0;
      link_up_out       <= 1'b0;
      signal_detect_out <= 1'b0;
    end
    else
    begin
      tx_enable_out     <= locked_q;
      link_up_out       <= (link_q == LINK_UP);
      signal_detect_out <= sd_q;
    end

  // register writes; extensions come out of reset bypassed
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
    begin
      ctrl_q   <= CTRL_RESET;
      on_q     <= ED_ON_RESET;
      off_q    <= ED_OFF_RESET;
      listen_q <= ED_LISTEN_RESET;
    end
    else if (wr_in)
    begin
      if (addr_in == CTRL_OFFSET)
        ctrl_q <= {13'h0000, wdata_in[2:0]};
      if (addr_in == ED_ON_OFFSET)
        on_q <= wdata_in;
      if (addr_in == ED_OFF_OFFSET)
        off_q <= wdata_in;
      if (addr_in == ED_LISTEN_OFFSET)
        listen_q <= wdata_in;
    end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
      rdata_out <= 16'h0000;
    else if (!rd_in)
      rdata_out <= 16'h0000;
    else
      unique case (addr_in)
        FALSE_CARRIER_OFFSET: rdata_out <= fcc_q;
        CTRL_OFFSET:          rdata_out <= ctrl_q;
        ED_ON_OFFSET:         rdata_out <= on_q;
        ED_OFF_OFFSET:        rdata_out <= off_q;
        ED_LISTEN_OFFSET:     rdata_out <= listen_q;
        STATUS_OFFSET:        rdata_out <= {9'h000, link_q, st_q, 1'b0, sd_q, locked_q};
        default:              rdata_out <= 16'h0000;
      endcase
endmodule : rx_decode_path

// ---- rx_decode_checker.sv ----
// Purpose: port-level properties of the rx decode path
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   ten_carrier_in history marks the 100M case
`timescale 1ns/1ps
module rx_decode_checker
  import rx_decode_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        nrst_in,
  input wire logic        rd_in,
  input wire logic        ten_carrier_in,
  input wire logic [15:0] rdata_out,
  input wire logic [3:0]  rxd_out,
  input wire logic        rx_dv_out,
  input wire logic        rx_er_out,
  input wire logic        crs_out,
  input wire logic        rx_strobe_out,
  input wire logic [1:0]  tx_mlt3_out,
  input wire logic        tx_enable_out,
  input wire logic        link_up_out,
  input wire logic        signal_detect_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [3:0] car_q;
  logic       lock_q;
  // dv may trail the 10M carrier by the synchroniser depth
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
      car_q <= 4'h0;
    else
      car_q <= {car_q[2:0], ten_carrier_in};
  // lock one cycle back, so a registered drop is not flagged
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
      lock_q <= 1'b0;
    else
      lock_q <= tx_enable_out;
  AST_RDATA_ZERO: assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("read data outside read slot");
  AST_NO_RX_UNLOCKED: assert property (!tx_enable_out && !lock_q && car_q == 4'h0
    |-> !rx_dv_out && !crs_out) else $error("receive active while unlocked");
  AST_STROBE_ONE: assert property (rx_strobe_out |=> !rx_strobe_out [*8])
    else $error("nibble strobes too close");
  AST_BAD_NIBBLE: assert property (rx_strobe_out && rx_er_out && !rx_dv_out
    |-> rxd_out == BAD_START_NIBBLE) else $error("bad start nibble wrong");
  AST_DV_PREAMBLE: assert property ($rose(rx_dv_out) && car_q == 4'h0
    |-> rxd_out == PREAMBLE_NIBBLE) else $error("packet did not open with preamble");
  AST_DV_CRS: assert property (rx_dv_out && car_q == 4'h0 |-> crs_out)
    else $error("data valid without carrier");
  AST_ER_CRS: assert property (rx_er_out && car_q == 4'h0 |-> crs_out)
    else $error("receive error outlived carrier");
  AST_MLT3_SEQ: assert property ($changed(tx_mlt3_out) && $past(tx_mlt3_out) != 2'b00
    |-> tx_mlt3_out == 2'b00) else $error("line level skipped zero");
  AST_MLT3_HOLD: assert property ($changed(tx_mlt3_out) |=> $stable(tx_mlt3_out) [*8])
    else $error("line level changed twice in a symbol");
  AST_LINK_CAUSE: assert property ($rose(link_up_out)
    |-> signal_detect_out && tx_enable_out) else $error("link up without cause");
  AST_LINK_DROP: assert property ($fell(signal_detect_out) |-> ##[0:2] !link_up_out)
    else $error("link stayed up after energy loss");
endmodule : rx_decode_checker

bind rx_decode_path rx_decode_checker i_chk (.sys_clk_in, .nrst_in, .rd_in, .ten_carrier_in,
  .rdata_out, .rxd_out, .rx_dv_out, .rx_er_out, .crs_out, .rx_strobe_out, .tx_mlt3_out,
  .tx_enable_out, .link_up_out, .signal_detect_out);

// ---- link_partner_model.sv ----
// Purpose: behavioural cable partner: symbol clock, line samples, 10M bits
// Assumes: the design samples the line at the rising link clock edge
// Notes:   recovered clock runs free; an idle cable reads level 0
`timescale 1ns/1ps
module link_partner_model
(
  input  wire logic  mdix_in,
  output logic       link_clk_out,
  output logic [7:0] pair_a_out,
  output logic [7:0] pair_b_out,
  output logic       ten_bit_out,
  output logic       ten_carrier_out
);
  logic [10:0] lfsr_q  = 11'h7FF;
  logic [1:0]  phase_q = 2'h0;
  logic        nrzi_q  = 1'b0;
  initial
  begin
    link_clk_out = 1'b0;
    pair_a_out = 8'h00;
    pair_b_out = 8'h00;
    ten_bit_out = 1'b0;
    ten_carrier_out = 1'b0;
  end
  // 160 ns symbol clock
  always #80 link_clk_out = ~link_clk_out;
  // the unused pair carries the negated live one, which decodes the same, so a wrong pick does not show up
  task automatic put(input logic [7:0] s);
    @(negedge link_clk_out);
    pair_a_out = mdix_in ? 8'(-s) : s;
    pair_b_out = mdix_in ? s : 8'(-s);
    ten_bit_out = ~ten_bit_out;
  endtask : put
  // scramble, nrzi encode, then an nrzi one steps the three-level phase
  task automatic sym(input logic d);
    logic k;
    k = lfsr_q[10] ^ lfsr_q[8];
    lfsr_q = {lfsr_q[9:0], k};
    nrzi_q = nrzi_q ^ d ^ k;
    if (nrzi_q)
      phase_q = phase_q + 2'h1;
    put(phase_q == 2'h1 ? 8'h40 : (phase_q == 2'h3 ? 8'hC0 : 8'h00));
  endtask : sym
  task automatic cg(input logic [4:0] c, input int n);
    repeat (n)
      for (int i = 4; i >= 0; i--)
        sym(c[i]);
  endtask : cg
  // carrier drops one symbol late, so the last 10M bit still counts
  task automatic quiet(input int n);
    repeat (n)
    begin
      put(8'h00);
      ten_carrier_out = 1'b0;
    end
  endtask : quiet
  // 10M decoded bits, lsb first
  task automatic ten(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge link_clk_out);
      ten_bit_out = b[i];
      ten_carrier_out = 1'b1;
    end
  endtask : ten
endmodule : link_partner_model

// ---- rx_decode_path_tb.sv ----
// Purpose: self-checking bench for rx_decode_path
// Assumes: partner model drives line, symbol clock and 10M bits
// Notes:   sync loss and recovery counts shortened by parameters
`timescale 1ns/1ps
module rx_decode_path_tb;
  import rx_decode_pkg::*;
  logic        sys_clk_in, nrst_in, mdix_in, tx_bit_in, wr_in, rd_in;
  logic        link_clk_in, ten_bit_in, ten_carrier_in, rx_dv_out, rx_er_out;
  logic        crs_out, rx_strobe_out, tx_enable_out, link_up_out, signal_detect_out;
  logic [7:0]  pair_a_in, pair_b_in, addr_in;
  logic [15:0] wdata_in, rdata_out, v, w;
  logic [3:0]  rxd_out;
  logic [1:0]  tx_mlt3_out;
  logic [5:0]  got[$];
  int          errors, cmp_count, n, e;
  logic [4:0]  enc[16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                           5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [7:0]  offs[5] = '{FALSE_CARRIER_OFFSET, CTRL_OFFSET, ED_ON_OFFSET, ED_OFF_OFFSET,
                           ED_LISTEN_OFFSET};
  logic [15:0] rsts[5] = '{FALSE_CARRIER_RESET, CTRL_RESET, ED_ON_RESET, ED_OFF_RESET,
                           ED_LISTEN_RESET};

  rx_decode_path #(.SYNC_LOSS_BITS(200), .RECOVER_TICKS(20)) i_dut (.sys_clk_in, .nrst_in,
    .link_clk_in, .pair_a_in, .pair_b_in, .mdix_in, .tx_bit_in, .ten_bit_in, .ten_carrier_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rxd_out, .rx_dv_out, .rx_er_out,
    .crs_out, .rx_strobe_out, .tx_mlt3_out, .tx_enable_out, .link_up_out, .signal_detect_out);
  link_partner_model p (.mdix_in, .link_clk_out(link_clk_in), .pair_a_out(pair_a_in),
    .pair_b_out(pair_b_in), .ten_bit_out(ten_bit_in), .ten_carrier_out(ten_carrier_in));

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // idles, start pair, 16 data groups, end pair; bad adds a stray start code
  task automatic frame(input logic bad);
    got.delete();
    p.cg(CG_IDLE, 4);
    p.cg(CG_J, 1);
    p.cg(CG_K, 1);
    for (int i = 0; i < 16; i++)
    begin
      if (bad && i == 8)
        p.cg(CG_J, 1);
      p.cg(enc[i], 1);
    end
    p.cg(CG_T, 1);
    p.cg(CG_R, 1);
    p.cg(CG_IDLE, 4);
    chk("dv_end", 16'(rx_dv_out), 16'h0000);
    n = 0;
    e = 0;
    foreach (got[i])
      if (got[i][5] && n < 18)
      begin
        if (!bad)
          chk("rxd", 16'(got[i][3:0]), n < 2 ? 16'(PREAMBLE_NIBBLE) : 16'(n - 2));
        e = e | int'(got[i][4]);
        n++;
      end
    chk("ctl_er", 16'(e), 16'(bad));
    chk("nibbles", 16'(n), 16'h0012);
  endtask : frame

  // 100 MHz system clock
  always #5 sys_clk_in = ~sys_clk_in;
  // every strobed nibble with its dv and er
  always @(posedge sys_clk_in)
    if (rx_strobe_out === 1'b1)
      got.push_back({rx_dv_out, rx_er_out, rxd_out});
  // hang guard
  initial
  begin
    repeat (60000) @(posedge sys_clk_in);
    errors++;
    wrap_up();
  end

  initial
  begin
    sys_clk_in = 1'b0;
    nrst_in = 1'b0;
    mdix_in = 1'b0;
    tx_bit_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 16'h0000;
    repeat (5) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(offs[i]);
      chk("reset_val", v, rsts[i]);
    end
    rd(8'h20);
    chk("unmapped", v, 16'h0000);
    wr(FALSE_CARRIER_OFFSET, 16'hFFFF);
    rd(FALSE_CARRIER_OFFSET);
    chk("fc_ro", v, 16'h0000);
    wr(ED_ON_OFFSET, 16'h0008);
    wr(ED_OFF_OFFSET, 16'h0004);
    wr(ED_LISTEN_OFFSET, 16'h0004);
    rd(ED_ON_OFFSET);
    chk("ed_on", v, 16'h0008);
    // transmit line: zero holds; steady ones alternate nrzi, one step per two symbols
    repeat (3) @(negedge link_clk_in);
    w = 16'(tx_mlt3_out);
    repeat (2) @(negedge link_clk_in);
    chk("mlt3_hold", 16'(tx_mlt3_out), w);
    @(posedge sys_clk_in);
    tx_bit_in <= ~tx_bit_in;
    repeat (2) @(negedge link_clk_in);
    w = 16'(tx_mlt3_out);
    repeat (2) @(negedge link_clk_in);
    chk("mlt3_step", 16'(16'(tx_mlt3_out) != w), 16'h0001);
    repeat (6) @(negedge link_clk_in);
    chk("mlt3_cycle", 16'(tx_mlt3_out), w);
    p.cg(CG_IDLE, 40);
    rd(STATUS_OFFSET);
    chk("locked", 16'(v[0]), 16'h0001);
    chk("link_up", 16'(link_up_out), 16'h0001);
    chk("link_st", 16'(v[6:5]), 16'h0001);
    chk("tx_en", 16'(tx_enable_out), 16'h0001);
    frame(1'b0);
    frame(1'b1);
    // bad start: data groups straight after idles
    got.delete();
    p.cg(CG_IDLE, 4);
    p.cg(enc[1], 3);
    p.cg(CG_IDLE, 4);
    n = 0;
    foreach (got[i])
      n = n + int'(got[i][4] && !got[i][5]);
    rd(FALSE_CARRIER_OFFSET);
    chk("fc_count", v, 16'(n));
    chk("bad_min", 16'(n >= 3), 16'h0001);
    chk("bad_end", 16'({rx_er_out, crs_out}), 16'h0000);
    @(posedge sys_clk_in);
    mdix_in <= ~mdix_in;
    p.cg(CG_IDLE, 10);
    frame(1'b0);
    p.quiet(120);
    chk("link_drop", 16'({signal_detect_out, link_up_out}), 16'h0000);
    wr(CTRL_OFFSET, 16'h0000);
    got.delete();
    p.ten(8'h55);
    p.ten(8'h55);
    p.ten(SFD_BYTE);
    p.ten(8'h3C);
    p.quiet(8);
    chk("ten_lo", 16'({got[0][5], got[0][3:0]}), 16'h001C);
    chk("ten_hi", 16'({got[1][5], got[1][3:0]}), 16'h0013);
    wrap_up();
  end
endmodule : rx_decode_path_tb
